// file: design/literal_branch_op_pkg.sv
/*
 * Constants, opcodes and carrier types for the literal, table, register
 * and branch execute unit. Assumes a core that runs four quarter phases
 * per instruction cycle on a single clock.
 */
package literal_branch_op_pkg;
  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int PC_W = 21;
  localparam int ADDR_W = 12;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  // ****************************************
  // Opcode fields
  // ****************************************
  localparam logic [7:0] OP_LIT_ADD = 8'h0f;
  localparam logic [7:0] OP_LIT_AND = 8'h0b;
  localparam logic [7:0] OP_LIT_OR = 8'h09;
  localparam logic [7:0] OP_LIT_XOR = 8'h0a;
  localparam logic [7:0] OP_LIT_MOV = 8'h0e;
  localparam logic [7:0] OP_LIT_MUL = 8'h0d;
  localparam logic [7:0] OP_LIT_RET = 8'h0c;
  localparam logic [7:0] OP_LIT_SUB = 8'h08;
  localparam logic [11:0] OP_BANK_LD = 12'h010;
  localparam logic [7:0] OP_PTR_LD = 8'hee;
  localparam logic [1:0] PTR_LD_MID = 2'h0;
  localparam logic [11:0] OP_TBL_PFX = 12'h000;
  localparam logic [5:0] OP_F_ADD = 6'h09;
  localparam logic [5:0] OP_F_ADDC = 6'h08;
  localparam logic [5:0] OP_F_AND = 6'h05;
  localparam logic [3:0] OP_BIT_CLR = 4'h9;
  localparam logic [7:0] OP_BR_C = 8'he2;
  localparam logic [7:0] OP_BR_NC = 8'he3;
  localparam logic [7:0] OP_BR_N = 8'he6;
  localparam logic [7:0] OP_BR_NN = 8'he7;
  localparam logic [7:0] OP_BR_NOV = 8'he5;
  // ****************************************
  // Table access modes and second-cycle kinds
  // ****************************************
  localparam logic [1:0] TBL_PLAIN = 2'h0;
  localparam logic [1:0] TBL_POST_INC = 2'h1;
  localparam logic [1:0] TBL_POST_DEC = 2'h2;
  localparam logic [1:0] TBL_PRE_INC = 2'h3;
  localparam logic [1:0] SEC_NONE = 2'h0;
  localparam logic [1:0] SEC_PTR = 2'h1;
  localparam logic [1:0] SEC_PROGRAM_MEMORY_READ = 2'h2;
  localparam logic [1:0] SEC_PROGRAM_MEMORY_WRITE = 2'h3;
  // Cycles beyond the normal two for a write that starts a flash cycle
  localparam logic [2:0] PROGRAM_MEMORY_WRITE_LONG_EXTRA = 3'h3;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } phase_t;
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } status_t;
  localparam status_t STATUS_RESET = 5'h00;
  typedef struct packed {
    logic [11:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } dm_req_t;
endpackage

// file: design/literal_branch_op_decoder.sv
/*
 * Execute unit for literal ops, table read/write, register add/and,
 * bit clear and carry/negative/overflow branches.
 * Assumes program memory returns, in each instruction cycle, the word
 * fetched at pc_q during the previous cycle, and that data memory and
 * the table port answer combinationally within the phase they are asked.
 */
// Functional notes
// - PC change or true test costs a second cycle run as no-op.
// - Second word alone decodes as no-op; used only by its first word.
// - Read-modify-write of a port register takes the pin levels.
// - Writing timer zero counter clears an assigned prescaler.
// - Table write lasts 2 cycles, 5 when it starts a flash write.
// - Literal add into working register, all five flags.
// - Literal and/or/xor into working register, zero and negative only.
// - Literal move and multiply leave every flag alone.
// - Literal minus working register, all five flags.
// - Return with literal loads working register, returns, two cycles.
// - Bank literal load sets bank select low nibble, no flags.
// - Two-word 12-bit load of the chosen indirect pointer.
// - Table read, two cycles, plain/post-inc/post-dec/pre-inc pointer.
// - Table write of latch, same four pointer modes.
// - Register add, one cycle, d picks destination.
// - a=0 forces the access bank, a=1 uses bank select.
// - Register add with carry, d picks destination, five flags.
// - Register and, d picks destination, negative and zero only.
// - Bit clear: read in Q2, write in Q4, no flags.
// - Taken branch goes to incremented PC plus twice signed offset.
// - Branch on carry set and on carry clear, no flag change.
// - Branch on negative, not negative, and no overflow.
// - Multiply product split into high and low product bytes.
`timescale 1ns/10ps
module literal_branch_op_decoder
  import literal_branch_op_pkg::*;
#(
  parameter logic [11:0] TIMER_ZERO_ADDR = 12'hf00,
  parameter int N_POINTERS = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Program memory
  input wire logic [15:0] instr_word,
  output logic [20:0] pc_q,
  // Data memory and port pins
  output dm_req_t dm_q,
  input wire logic [7:0] dm_rdata,
  input wire logic port_hit,
  input wire logic [7:0] pin_levels,
  // Timer zero prescaler
  input wire logic prescaler_assigned,
  output logic prescaler_clr_q,
  // Table access
  input wire logic [7:0] tbl_rdata,
  input wire logic pm_write_start,
  output logic [20:0] table_pointer_q,
  output logic [7:0] table_latch_q,
  output logic tbl_rd_q,
  output logic tbl_wr_q,
  // Return stack
  input wire logic [20:0] tos,
  output logic stack_pop_q,
  // Core state
  output logic [7:0] working_register_q,
  output status_t status_q,
  output logic [3:0] bank_select_register_q,
  output logic [N_POINTERS-1:0][11:0] indirect_pointer_q,
  output logic [7:0] product_high_q,
  output logic [7:0] product_low_q
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [10:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic ci);
    logic [4:0] lo;
    logic [8:0] full;
    logic ov;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    ov = (a[7] == b[7]) && (full[7] != a[7]);
    return {full[8], lo[4], ov, full[7:0]};
  endfunction

  function automatic logic reads_f(input logic [15:0] w);
    return w[15:10] == OP_F_ADD || w[15:10] == OP_F_ADDC ||
           w[15:10] == OP_F_AND || w[15:12] == OP_BIT_CLR;
  endfunction

  function automatic logic [11:0] f_addr(input logic [15:0] w,
                                         input logic [3:0] bank);
    if (w[8]) begin
      return {bank, w[7:0]};
    end
    return (w[7:0] < ACCESS_SPLIT) ? {4'h0, w[7:0]} :
           {ACCESS_HI_BANK, w[7:0]};
  endfunction

  phase_t phase_q;
  logic [15:0] ir_q;
  logic live_q, hold_q;
  logic [2:0] skip_q;
  logic [1:0] sec_q, tmode_q, psel_q;
  logic [3:0] phi_q;
  logic [7:0] opnd_q;
  logic [7:0] k, alu_res;
  logic lit_add, lit_and, lit_or, lit_xor, lit_mov, lit_mul, lit_sub;
  logic lit_ret, bank_ld, ptr_ld, tbl_op, f_add, f_addc, f_and, f_bcf;
  logic br_taken, wr_f, wr_w, multi, upd_all, upd_zn;
  logic [10:0] sum;
  status_t flg_new;
  logic [20:0] br_target;
  logic commit;
  logic stall_more;

  assign commit = phase_q == PH_Q4 && live_q;
  // Table stall goes on past this cycle: the pc must not move yet
  assign stall_more = skip_q > 3'h1 ||
                      (sec_q == SEC_PROGRAM_MEMORY_WRITE && pm_write_start);

  // ****************************************
  // Decode
  // ****************************************
  always_comb begin
    k = ir_q[7:0];
    lit_add = ir_q[15:8] == OP_LIT_ADD;
    lit_and = ir_q[15:8] == OP_LIT_AND;
    lit_or = ir_q[15:8] == OP_LIT_OR;
    lit_xor = ir_q[15:8] == OP_LIT_XOR;
    lit_mov = ir_q[15:8] == OP_LIT_MOV;
    lit_mul = ir_q[15:8] == OP_LIT_MUL;
    lit_sub = ir_q[15:8] == OP_LIT_SUB;
    lit_ret = ir_q[15:8] == OP_LIT_RET;
    bank_ld = ir_q[15:4] == OP_BANK_LD;
    ptr_ld = ir_q[15:8] == OP_PTR_LD && ir_q[7:6] == PTR_LD_MID;
    tbl_op = ir_q[15:4] == OP_TBL_PFX && ir_q[3];
    f_add = ir_q[15:10] == OP_F_ADD;
    f_addc = ir_q[15:10] == OP_F_ADDC;
    f_and = ir_q[15:10] == OP_F_AND;
    f_bcf = ir_q[15:12] == OP_BIT_CLR;
    // Second words (top nibble all ones) match nothing here
    case (ir_q[15:8])
      OP_BR_C: br_taken = status_q.c;
      OP_BR_NC: br_taken = !status_q.c;
      OP_BR_N: br_taken = status_q.n;
      OP_BR_NN: br_taken = !status_q.n;
      OP_BR_NOV: br_taken = !status_q.ov;
      default: br_taken = 1'b0;
    endcase
    wr_f = f_bcf || ((f_add || f_addc || f_and) && ir_q[9]);
    wr_w = lit_add || lit_and || lit_or || lit_xor || lit_mov ||
           lit_sub || lit_ret ||
           ((f_add || f_addc || f_and) && !ir_q[9]);
    multi = br_taken || lit_ret || ptr_ld || tbl_op;
    upd_all = lit_add || lit_sub || f_add || f_addc;
    upd_zn = lit_and || lit_or || lit_xor || f_and;
  end

  // ****************************************
  // Process data (Q3 operands are stable through Q4)
  // ****************************************
  always_comb begin
    sum = 11'h000;
    if (lit_add) begin
      sum = add8(working_register_q, k, 1'b0);
    end else if (lit_sub) begin
      sum = add8(k, ~working_register_q, 1'b1);
    end else if (f_add) begin
      sum = add8(working_register_q, opnd_q, 1'b0);
    end else if (f_addc) begin
      sum = add8(working_register_q, opnd_q, status_q.c);
    end
    alu_res = k;
    if (upd_all) begin
      alu_res = sum[7:0];
    end else if (lit_and) begin
      alu_res = working_register_q & k;
    end else if (lit_or) begin
      alu_res = working_register_q | k;
    end else if (lit_xor) begin
      alu_res = working_register_q ^ k;
    end else if (f_and) begin
      alu_res = working_register_q & opnd_q;
    end else if (f_bcf) begin
      alu_res = opnd_q & ~(8'h01 << ir_q[11:9]);
    end
    flg_new = status_q;
    if (upd_all) begin
      flg_new.c = sum[10];
      flg_new.dc = sum[9];
      flg_new.ov = sum[8];
    end
    if (upd_all || upd_zn) begin
      flg_new.z = alu_res == 8'h00;
      flg_new.n = alu_res[7];
    end
    br_target = pc_q + {{12{k[7]}}, k, 1'b0};
  end

  // ****************************************
  // Phase sequencing
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= PH_Q1;
    end else begin
      case (phase_q)
        PH_Q1: phase_q <= PH_Q2;
        PH_Q2: phase_q <= PH_Q3;
        PH_Q3: phase_q <= PH_Q4;
        PH_Q4: phase_q <= PH_Q1;
        default: phase_q <= PH_Q1;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_q <= 16'h0000;
      live_q <= 1'b0;
    end else if (phase_q == PH_Q1) begin
      ir_q <= instr_word;
      live_q <= skip_q == 3'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      skip_q <= 3'h0;
      sec_q <= SEC_NONE;
      hold_q <= 1'b0;
      tmode_q <= TBL_PLAIN;
      psel_q <= 2'h0;
      phi_q <= 4'h0;
    end else if (commit) begin
      skip_q <= multi ? 3'h1 : 3'h0;
      hold_q <= tbl_op;
      tmode_q <= ir_q[1:0];
      psel_q <= ir_q[5:4];
      phi_q <= ir_q[3:0];
      sec_q <= ptr_ld ? SEC_PTR : !tbl_op ? SEC_NONE :
               ir_q[2] ? SEC_PROGRAM_MEMORY_WRITE : SEC_PROGRAM_MEMORY_READ;
    end else if (phase_q == PH_Q4) begin
      sec_q <= SEC_NONE;
      // A started flash write stalls the core until it ends
      if (sec_q == SEC_PROGRAM_MEMORY_WRITE && pm_write_start) begin
        skip_q <= PROGRAM_MEMORY_WRITE_LONG_EXTRA;
      end else if (skip_q != 3'h0) begin
        skip_q <= skip_q - 3'h1;
      end
    end
  end

  // Table stalls hold the fetch so the prefetched word is not lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q <= PC_RESET;
    end else if (commit && br_taken) begin
      pc_q <= br_target;
    end else if (commit && lit_ret) begin
      pc_q <= tos;
    end else if (commit && !tbl_op) begin
      pc_q <= pc_q + PC_STEP;
    end else if (phase_q == PH_Q4 && !live_q && !(hold_q && stall_more)) begin
      pc_q <= pc_q + PC_STEP;
    end
  end

  // ****************************************
  // Data memory and timer prescaler
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dm_q <= '0;
      opnd_q <= 8'h00;
      prescaler_clr_q <= 1'b0;
    end else begin
      case (phase_q)
        PH_Q1: begin
          dm_q.addr <= f_addr(instr_word, bank_select_register_q);
          dm_q.rd <= skip_q == 3'h0 && reads_f(instr_word);
        end
        PH_Q2: begin
          dm_q.rd <= 1'b0;
          opnd_q <= (port_hit && wr_f) ? pin_levels : dm_rdata;
        end
        PH_Q3: begin
          dm_q.wr <= live_q && wr_f;
          dm_q.wdata <= alu_res;
          prescaler_clr_q <= live_q && wr_f && prescaler_assigned &&
                             dm_q.addr == TIMER_ZERO_ADDR;
        end
        PH_Q4: begin
          dm_q.wr <= 1'b0;
          prescaler_clr_q <= 1'b0;
        end
        default: dm_q.rd <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // Write-back of core state
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      working_register_q <= 8'h00;
      status_q <= STATUS_RESET;
      bank_select_register_q <= 4'h0;
      product_high_q <= 8'h00;
      product_low_q <= 8'h00;
      stack_pop_q <= 1'b0;
    end else begin
      stack_pop_q <= commit && lit_ret;
      if (commit) begin
        if (wr_w) begin
          working_register_q <= alu_res;
        end
        status_q <= flg_new;
        if (bank_ld) begin
          bank_select_register_q <= ir_q[3:0];
        end
        if (lit_mul) begin
          {product_high_q, product_low_q} <= k * working_register_q;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      indirect_pointer_q <= '0;
    end else if (phase_q == PH_Q4 && !live_q && sec_q == SEC_PTR &&
                 32'(psel_q) < N_POINTERS) begin
      indirect_pointer_q[psel_q] <= {phi_q, ir_q[7:0]};
    end
  end

  // ****************************************
  // Table read and write
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      table_pointer_q <= 21'h000000;
      table_latch_q <= 8'h00;
      tbl_rd_q <= 1'b0;
      tbl_wr_q <= 1'b0;
    end else if (phase_q == PH_Q1) begin
      tbl_rd_q <= sec_q == SEC_PROGRAM_MEMORY_READ;
      tbl_wr_q <= sec_q == SEC_PROGRAM_MEMORY_WRITE;
    end else if (phase_q == PH_Q2) begin
      tbl_rd_q <= 1'b0;
      tbl_wr_q <= 1'b0;
      if (tbl_rd_q) begin
        table_latch_q <= tbl_rdata;
      end
    end else if (commit && tbl_op && ir_q[1:0] == TBL_PRE_INC) begin
      table_pointer_q <= table_pointer_q + 21'h000001;
    end else if (phase_q == PH_Q4 && !live_q && sec_q != SEC_NONE &&
                 sec_q != SEC_PTR) begin
      if (tmode_q == TBL_POST_INC) begin
        table_pointer_q <= table_pointer_q + 21'h000001;
      end else if (tmode_q == TBL_POST_DEC) begin
        table_pointer_q <= table_pointer_q - 21'h000001;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_phase_order;
    phase_q == PH_Q1 |=> phase_q == PH_Q2 ##1 phase_q == PH_Q3
      ##1 phase_q == PH_Q4 ##1 phase_q == PH_Q1;
  endproperty
  a_phase_order: assert property (p_phase_order)
    else $error("quarter phases out of order");

  property p_taken_nop;
    commit && br_taken |-> ##2 !live_q ##4 live_q;
  endproperty
  a_taken_nop: assert property (p_taken_nop)
    else $error("taken branch not followed by one no-op cycle");

  property p_branch_target;
    commit && br_taken |=> pc_q == $past(br_target);
  endproperty
  a_branch_target: assert property (p_branch_target)
    else $error("branch target wrong");

  property p_move_no_flags;
    commit && lit_mov |=> working_register_q == $past(k) &&
      $stable(status_q);
  endproperty
  a_move_no_flags: assert property (p_move_no_flags)
    else $error("literal move wrong or touched flags");

  property p_logic_flags;
    commit && (lit_and || lit_or || lit_xor) |=>
      status_q.c == $past(status_q.c) && status_q.ov == $past(status_q.ov)
      && status_q.z == (working_register_q == 8'h00);
  endproperty
  a_logic_flags: assert property (p_logic_flags)
    else $error("literal logic op flags wrong");

  property p_mul_split;
    commit && lit_mul |=>
      {product_high_q, product_low_q} == $past(k) * $past(working_register_q);
  endproperty
  a_mul_split: assert property (p_mul_split)
    else $error("product bytes wrong");

  property p_write_q4;
    dm_q.wr |-> phase_q == PH_Q4 && $past(dm_q.rd, 2);
  endproperty
  a_write_q4: assert property (p_write_q4)
    else $error("data write outside Q4 or without read");

  property p_long_write;
    phase_q == PH_Q4 && sec_q == SEC_PROGRAM_MEMORY_WRITE && pm_write_start |=>
      skip_q == 3'h3 ##1 !live_q [*4];
  endproperty
  a_long_write: assert property (p_long_write)
    else $error("table write did not stall three more cycles");

  property p_ret_pop;
    commit && lit_ret |=> pc_q == $past(tos) && stack_pop_q &&
      working_register_q == $past(k);
  endproperty
  a_ret_pop: assert property (p_ret_pop)
    else $error("return with literal wrong");

  c_branch: cover property (commit && br_taken);
  c_long_write: cover property (sec_q == SEC_PROGRAM_MEMORY_WRITE && pm_write_start);
  c_ptr_load: cover property (phase_q == PH_Q4 && sec_q == SEC_PTR);
  c_port_rmw: cover property (phase_q == PH_Q2 && port_hit && wr_f);
endmodule

// file: verif/prog_mem_model.sv
/*
 * Program memory partner: 256 words, aliased on pc bits 8:1.
 * Assumes the core takes a word at every fourth edge after reset,
 * the first one at the first edge after release.
 */
`timescale 1ns/10ps
module prog_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fetch port
  input wire logic [20:0] pc_q,
  output logic [15:0] instr_word
);
  // ****************************************
  // Fetch pipeline
  // ****************************************
  logic [15:0] mem [256];
  logic [1:0] ph_q;
  // Word fetched in one cycle is handed over for the next Q1 edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_q <= 2'h0;
      instr_word <= 16'h0000;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3) begin
        instr_word <= mem[pc_q[8:1]];
      end
    end
  end
endmodule

// file: verif/literal_branch_op_decoder_test.sv
/*
 * Self-checking bench for the literal, table, register and branch unit.
 * Assumes the program memory model feeds words; the bench plays data
 * memory, the table port and the return stack.
 */
`timescale 1ns/10ps
module literal_branch_op_decoder_test;
  import literal_branch_op_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] instr_word, iw;
  logic [20:0] pc_q, table_pointer_q, pcx, tos = 21'h0, tp = 21'h0;
  dm_req_t dm_q;
  logic [7:0] dm_rdata = 8'h00, pin_levels = 8'h00, tbl_rdata = 8'h00;
  logic port_hit = 1'b0, prescaler_assigned = 1'b0, pm_write_start = 1'b0;
  logic prescaler_clr_q, tbl_rd_q, tbl_wr_q, stack_pop_q, d, a, tk;
  logic [7:0] table_latch_q, working_register_q;
  logic [7:0] product_high_q, product_low_q, k, opnd, res, op8, wd;
  logic [7:0] w = 8'h00;
  status_t status_q, st = STATUS_RESET;
  logic [3:0] bank_select_register_q;
  logic [2:0][11:0] indirect_pointer_q;
  logic [15:0] prod = 16'h0000;
  logic [11:0] wa, ea, kk;
  logic [31:0] r, r2, seed = 32'd56756;
  logic [1:0] md;
  logic [7:0] lits [8] = '{OP_LIT_ADD, OP_LIT_AND, OP_LIT_OR, OP_LIT_XOR,
    OP_LIT_MOV, OP_LIT_MUL, OP_LIT_SUB, 8'hf0};
  logic [7:0] brs [5] = '{OP_BR_C, OP_BR_NC, OP_BR_N, OP_BR_NN, OP_BR_NOV};
  int mismatches = 0, comparisons = 0, cycles = 0, x, i;
  int pclr = 0, pops = 0, twr = 0, epclr = 0, epops = 0, etwr = 0;
  int trd = 0, etrd = 0, drd = 0, edrd = 0;

  always #20 clk = ~clk;

  literal_branch_op_decoder DUT (.clk, .rst, .instr_word, .pc_q, .dm_q,
    .dm_rdata, .port_hit, .pin_levels, .prescaler_assigned,
    .prescaler_clr_q, .tbl_rdata, .pm_write_start, .table_pointer_q,
    .table_latch_q, .tbl_rd_q, .tbl_wr_q, .tos, .stack_pop_q,
    .working_register_q, .status_q, .bank_select_register_q,
    .indirect_pointer_q, .product_high_q, .product_low_q);
  prog_mem_model pm (.clk, .rst, .pc_q, .instr_word);

  // ****************************************
  // Helpers
  // ****************************************
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Returns {n, ov, z, dc, c, sum}
  function automatic logic [12:0] addf(input logic [7:0] p, q,
                                       input logic ci);
    logic [8:0] s;
    logic [4:0] l;
    s = p + q + ci;
    l = p[3:0] + q[3:0] + ci;
    return {s[7], p[7] == q[7] && s[7] != p[7], s[7:0] == 8'h00, l[4],
            s[8], s[7:0]};
  endfunction
  task check(input string nm, input logic [20:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Places a word at the fetch address, then lets one cycle pass
  task put(input logic [15:0] v);
    pm.mem[pc_q[8:1]] = v;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task op(input logic [15:0] v);
    put(v);
    put(16'h0000);
  endtask
  task stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Sampled before the edge's own updates land
  always @(posedge clk) begin
    cycles++;
    if (dm_q.wr) begin
      wa = dm_q.addr;
      wd = dm_q.wdata;
    end
    pclr += prescaler_clr_q;
    pops += stack_pop_q;
    twr += tbl_wr_q;
    trd += tbl_rd_q;
    drd += dm_q.rd;
    if (cycles == 4000) begin
      mismatches++;
      stop_test();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    for (x = 0; x < 256; x++) begin
      pm.mem[x] = 16'h0000;
    end
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (x = 0; x < 24; x++) begin
      op8 = lits[x % 8];
      k = (x < 8) ? 8'hff : 8'(rnd());
      op({op8, k});
      case (op8)
        OP_LIT_ADD: {st, w} = addf(w, k, 1'b0);
        OP_LIT_SUB: {st, w} = addf(k, ~w, 1'b1);
        OP_LIT_AND: w = w & k;
        OP_LIT_OR: w = w | k;
        OP_LIT_XOR: w = w ^ k;
        OP_LIT_MOV: w = k;
        OP_LIT_MUL: prod = w * k;
        default: ;
      endcase
      if (op8 inside {OP_LIT_AND, OP_LIT_OR, OP_LIT_XOR}) begin
        st.n = w[7];
        st.z = w == 8'h00;
      end
      check("w", working_register_q, w);
      check("status", status_q, st);
      check("prod", {product_high_q, product_low_q}, prod);
    end
    $display("literal test done");
    for (x = 0; x < 3; x++) begin
      kk = 12'(rnd());
      put({OP_PTR_LD, PTR_LD_MID, x[1:0], kk[11:8]});
      put({8'hf0, kk[7:0]});
      put(16'h0000);
      check("pointer", indirect_pointer_q[x], kk);
    end
    op({OP_BANK_LD, 4'hf});
    check("bank", bank_select_register_q, 4'hf);
    $display("load test done");
    for (x = 0; x < 24; x++) begin
      r = rnd();
      r2 = rnd();
      md = x[1:0];
      d = r[0] | (x == 0);
      a = r[1] | (x == 0);
      k = (x == 0) ? 8'h00 : r[15:8];
      port_hit = r[19];
      prescaler_assigned = r[20] | (x == 0);
      dm_rdata = r2[7:0];
      pin_levels = r2[15:8];
      ea = a ? {4'hf, k} : (k < ACCESS_SPLIT ? {4'h0, k}
                                             : {ACCESS_HI_BANK, k});
      opnd = (port_hit && (d || md == 2'h3)) ? pin_levels : dm_rdata;
      case (md)
        2'h0: {st, res} = addf(w, opnd, 1'b0);
        2'h1: {st, res} = addf(w, opnd, st.c);
        2'h2: res = w & opnd;
        default: res = opnd & ~(8'h01 << r[18:16]);
      endcase
      if (md == 2'h2) begin
        st.n = res[7];
        st.z = res == 8'h00;
      end
      case (md)
        2'h0: iw = {OP_F_ADD, d, a, k};
        2'h1: iw = {OP_F_ADDC, d, a, k};
        2'h2: iw = {OP_F_AND, d, a, k};
        default: iw = {OP_BIT_CLR, r[18:16], a, k};
      endcase
      wa = 'x;
      wd = 'x;
      op(iw);
      if (d || md == 2'h3) begin
        check("waddr", wa, ea);
        check("wdata", wd, res);
        epclr += (ea == 12'hf00 && prescaler_assigned);
      end else begin
        w = res;
      end
      check("w", working_register_q, w);
      check("status", status_q, st);
      check("prescaler", pclr, epclr);
      edrd++;
      check("dm reads", drd, edrd);
    end
    $display("register test done");
    for (x = 0; x < 30; x++) begin
      r = rnd();
      if (x < 2) begin
        r[15:8] = x ? 8'h7f : 8'h80;
      end
      op({OP_LIT_ADD, r[7:0]});
      {st, w} = addf(w, r[7:0], 1'b0);
      op8 = brs[x % 5];
      case (op8)
        OP_BR_C: tk = st.c;
        OP_BR_NC: tk = !st.c;
        OP_BR_N: tk = st.n;
        OP_BR_NN: tk = !st.n;
        default: tk = !st.ov;
      endcase
      pcx = pc_q;
      put({op8, r[15:8]});
      put({OP_LIT_MOV, r[23:16]});
      check("pc", pc_q, tk ? pcx + 21'h2 + {{12{r[15]}}, r[15:8], 1'b0}
                           : pcx + 21'h4);
      put(16'h0000);
      if (!tk) begin
        w = r[23:16];
      end
      check("w", working_register_q, w);
      check("status", status_q, st);
    end
    $display("branch test done");
    for (x = 0; x < 3; x++) begin
      r = rnd();
      tos = {r[20:1], 1'b0};
      put({OP_LIT_RET, r[31:24]});
      put({OP_LIT_MOV, r[7:0]});
      check("pc", pc_q, tos);
      put(16'h0000);
      w = r[31:24];
      epops++;
      check("w", working_register_q, w);
      check("pops", pops, epops);
    end
    $display("return test done");
    for (x = 0; x < 8; x++) begin
      r = rnd();
      md = x[1:0];
      pm_write_start = x == 5 || x == 7;
      tbl_rdata = r[7:0];
      pcx = pc_q;
      if (md == TBL_PRE_INC) begin
        tp++;
      end
      // No rewrites while the pc is held: the word after must survive
      for (i = 2; i < 8; i++) begin
        pm.mem[8'(pcx[8:1] + i)] = 16'h0000;
      end
      pm.mem[pcx[8:1]] = {OP_TBL_PFX, 1'b1, x[2], md};
      pm.mem[8'(pcx[8:1] + 1)] = {OP_LIT_MOV, r[15:8]};
      repeat (28) @(negedge clk);
      if (md == TBL_POST_INC) begin
        tp++;
      end else if (md == TBL_POST_DEC) begin
        tp--;
      end
      check("table_pointer", table_pointer_q, tp);
      check("pc", pc_q, pcx + (pm_write_start ? 21'h6 : 21'hc));
      if (x[2]) begin
        etwr++;
      end else begin
        etrd++;
        check("latch", table_latch_q, r[7:0]);
      end
      check("writes", twr, etwr);
      check("reads", trd, etrd);
      w = r[15:8];
      check("w", working_register_q, w);
      pm_write_start = 1'b0;
    end
    $display("table test done");
    stop_test();
  end
endmodule
